// *** rtl/pum_datapath.sv ***
/*
 * Pixel update path with its pixel transfer FIFO and the video memory
 * read-ahead cache. Holds pum_fifo and the top module pum_datapath.
 * Assumes host port, engine and video memory logic all run on clk_sys_i.
 */
// What this block does
// - Cache enabled prefetches extra units, hits answer fast
// - Caching covers linear and legacy aperture reads
// - Prefetch counts dwords, words or bytes by mode
// - Coherency by invalidation, never by update
// - Pixel data via low or high port, one FIFO word each
// - Compare off passes new colour to mask stage
// - Masked planes unchanged, unmasked planes take colour
// - Compare on: pass on match, or mismatch if sensed
// - Comparison uses the new colour, not source or bitmap
// - New colour is mix of source and bitmap
// - Mix field selects back, fore, CPU or bitmap
// - Mix field selects one of 16 logic operations
// - Mask one uses fore mix, zero back mix
// - Mask source 00 forces mask bit one
// - Mask source 10 takes CPU bits after command
// - Mask source 11: all read planes set gives one
`timescale 1ns/1ps

module pum_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes and honest flags
    assign in_ready_o = (cnt_q != CW'(D));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rptr_q];

    // Storage
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wptr_q] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(D - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(D - 1)) ? '0 : rptr_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule

module pum_datapath (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Host I/O port
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    output logic px_fifo_full_o,
    // Read-ahead cache controls
    input wire logic cache_en_i,
    input wire logic [2:0] prefetch_cnt_i,
    input wire logic [1:0] access_size_i,
    // CPU video memory accesses
    input wire logic cpu_mrd_i,
    input wire logic cpu_mwr_i,
    input wire logic [pum_pkg::PUM_AW-1:0] cpu_maddr_i,
    output logic cpu_mbusy_o,
    output logic cpu_mvalid_o,
    output logic [31:0] cpu_mdata_o,
    // Drawing engine pixel requests
    input wire logic px_valid_i,
    input wire logic [pum_pkg::PUM_AW-1:0] px_addr_i,
    output logic px_ready_o,
    // Video memory port
    output logic vm_req_o,
    output pum_pkg::pum_vm_req_s vm_cmd_o,
    input wire logic [31:0] vm_rdata_i,
    input wire logic vm_rvalid_i
);
    import pum_pkg::*;

    logic [15:0] back_color_q;
    logic [15:0] fore_color_q;
    logic [15:0] plane_mask_q;
    logic [15:0] cmp_color_q;
    logic [15:0] back_mix_q;
    logic [15:0] fore_mix_q;
    logic [15:0] mask_src_q;
    logic [15:0] misc_q;
    logic [15:0] io_rdata_q;
    logic armed_q;
    pum_state_e state_q;
    logic busy_q;
    logic px_ready_q;
    logic mvalid_q;
    logic [31:0] mdata_q;
    logic vm_req_q;
    pum_vm_req_s vm_cmd_q;
    logic [PUM_AW-1:0] base_q;
    logic [2:0] cnt_q;
    logic [1:0] size_q;
    logic [2:0] fill_k_q;
    logic [2:0] req_idx_q;
    logic cache_valid_q;
    logic stale_q;
    logic [31:0] line_q [PUM_LINE_DEPTH];
    logic [15:0] dst_q;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PUM_FIFO_WIDTH-1:0] fifo_word;
    logic [2:0] fill_cnt;
    logic hit;
    logic mem_write;
    logic [1:0] msrc;
    logic mask_bit;
    logic [15:0] mix_sel;
    logic [15:0] src_color;
    logic [15:0] new_color;
    logic need_cpu;
    logic calc_go;
    logic pass;

    // Aligned start of a prefetch run
    function automatic logic [PUM_AW-1:0] align(
        input logic [PUM_AW-1:0] a,
        input logic [2:0] c
    );
        return a & ~{{(PUM_AW-3){1'b0}}, c};
    endfunction

    // The sixteen logic operations on source s and destination d
    function automatic logic [15:0] mix_op(
        input logic [3:0] op,
        input logic [15:0] s,
        input logic [15:0] d
    );
        logic [15:0] r;
        r = '0;
        case (op)
            4'h0: r = ~d;
            4'h1: r = '0;
            4'h2: r = '1;
            4'h3: r = d;
            4'h4: r = ~s;
            4'h5: r = s ^ d;
            4'h6: r = ~(s ^ d);
            4'h7: r = s;
            4'h8: r = ~s | ~d;
            4'h9: r = ~s | d;
            4'ha: r = s | ~d;
            4'hb: r = s | d;
            4'hc: r = s & d;
            4'hd: r = ~s & d;
            4'he: r = s & ~d;
            default: r = ~s & ~d;
        endcase
        return r;
    endfunction

    // Pixel transfer FIFO: both ports push one 16-bit word in write order
    assign fifo_in_valid = io_wr_i && ((io_addr_i == PUM_ADR_PIX_LOW) ||
        (io_addr_i == PUM_ADR_PIX_HIGH));
    assign fifo_out_ready = calc_go && need_cpu;

    pum_fifo #(
        .W(PUM_FIFO_WIDTH),
        .D(PUM_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(io_wdata_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_word)
    );

    // Mask bit, mix choice and colour source
    assign msrc = mask_src_q[PUM_MSRC_HI:PUM_MSRC_LO];
    always_comb begin
        case (msrc)
            PUM_MSK_CPU: mask_bit = fifo_word[0];
            PUM_MSK_BITMAP: mask_bit = &(dst_q | ~plane_mask_q);
            default: mask_bit = 1'b1;
        endcase
        mix_sel = mask_bit ? fore_mix_q : back_mix_q;
        case (mix_sel[PUM_MIX_SRC_HI:PUM_MIX_SRC_LO])
            PUM_SRC_BACK: src_color = back_color_q;
            PUM_SRC_FORE: src_color = fore_color_q;
            PUM_SRC_CPU: src_color = fifo_word;
            default: src_color = dst_q;
        endcase
    end

    // New colour and compare gate on the new colour
    assign new_color = mix_op(mix_sel[PUM_MIX_OP_HI:PUM_MIX_OP_LO],
        src_color, dst_q);
    assign pass = !misc_q[PUM_MISC_CMP_EN] ||
        ((new_color == cmp_color_q) ^ misc_q[PUM_MISC_SENSE]);
    assign need_cpu = (msrc == PUM_MSK_CPU) ||
        (mix_sel[PUM_MIX_SRC_HI:PUM_MIX_SRC_LO] == PUM_SRC_CPU);
    assign calc_go = (state_q == PUM_PX_CALC) &&
        (!need_cpu || (fifo_out_valid && armed_q));

    // Cache lookup and prefetch length in the current access unit
    assign fill_cnt = cache_en_i ? prefetch_cnt_i : '0;
    assign hit = cache_en_i && cache_valid_q && (size_q == access_size_i) &&
        (align(cpu_maddr_i, cnt_q) == base_q);
    assign mem_write = cpu_mwr_i || (calc_go && pass);

    // Host register writes
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            back_color_q <= PUM_REG_RST;
            fore_color_q <= PUM_REG_RST;
            plane_mask_q <= PUM_REG_RST;
            cmp_color_q <= PUM_REG_RST;
            back_mix_q <= PUM_REG_RST;
            fore_mix_q <= PUM_REG_RST;
            mask_src_q <= PUM_REG_RST;
            misc_q <= PUM_REG_RST;
            armed_q <= 1'b0;
        end else if (io_wr_i) begin
            if (io_addr_i == PUM_ADR_DRAW_CMD) begin
                armed_q <= 1'b1;
            end else if (io_addr_i == PUM_ADR_BACK_COLOR) begin
                back_color_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_FORE_COLOR) begin
                fore_color_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_PLANE_MASK) begin
                plane_mask_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_CMP_COLOR) begin
                cmp_color_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_BACK_MIX) begin
                back_mix_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_FORE_MIX) begin
                fore_mix_q <= io_wdata_i;
            end else if (io_addr_i == PUM_ADR_MULTI) begin
                if (io_wdata_i[PUM_IDX_HI:PUM_IDX_LO] == PUM_IDX_MASK_SRC) begin
                    mask_src_q <= io_wdata_i;
                end else if (io_wdata_i[PUM_IDX_HI:PUM_IDX_LO] == PUM_IDX_MISC) begin
                    misc_q <= io_wdata_i;
                end
            end
        end
    end

    // Host register reads, one cycle later
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_rdata_q <= '0;
        end else if (io_rd_i) begin
            if (io_addr_i == PUM_ADR_BACK_COLOR) begin
                io_rdata_q <= back_color_q;
            end else if (io_addr_i == PUM_ADR_FORE_COLOR) begin
                io_rdata_q <= fore_color_q;
            end else if (io_addr_i == PUM_ADR_PLANE_MASK) begin
                io_rdata_q <= plane_mask_q;
            end else if (io_addr_i == PUM_ADR_CMP_COLOR) begin
                io_rdata_q <= cmp_color_q;
            end else if (io_addr_i == PUM_ADR_BACK_MIX) begin
                io_rdata_q <= back_mix_q;
            end else if (io_addr_i == PUM_ADR_FORE_MIX) begin
                io_rdata_q <= fore_mix_q;
            end else if (io_addr_i == PUM_ADR_MULTI) begin
                io_rdata_q <= mask_src_q;
            end else if (io_addr_i == PUM_ADR_PIX_LOW ||
                         io_addr_i == PUM_ADR_PIX_HIGH) begin
                io_rdata_q <= dst_q; // Last bitmap colour fetched
            end else begin
                io_rdata_q <= '0;
            end
        end
    end

    // Video memory sequencer: CPU reads first, then engine pixels
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= PUM_IDLE;
            busy_q <= 1'b0;
            px_ready_q <= 1'b1;
            mvalid_q <= 1'b0;
            mdata_q <= '0;
            vm_req_q <= 1'b0;
            vm_cmd_q <= '0;
            base_q <= '0;
            cnt_q <= '0;
            size_q <= PUM_SZ_BYTE;
            fill_k_q <= '0;
            req_idx_q <= '0;
            dst_q <= '0;
        end else begin
            mvalid_q <= 1'b0;
            vm_req_q <= 1'b0;
            case (state_q)
                PUM_IDLE: begin
                    if (cpu_mrd_i && hit) begin
                        mdata_q <= line_q[cpu_maddr_i[2:0] & cnt_q];
                        mvalid_q <= 1'b1;
                    end else if (cpu_mrd_i) begin
                        base_q <= align(cpu_maddr_i, fill_cnt);
                        cnt_q <= fill_cnt;
                        size_q <= access_size_i;
                        req_idx_q <= cpu_maddr_i[2:0] & fill_cnt;
                        fill_k_q <= '0;
                        busy_q <= 1'b1;
                        px_ready_q <= 1'b0;
                        state_q <= PUM_CA_ISSUE;
                    end else if (px_valid_i && px_ready_q) begin
                        vm_req_q <= 1'b1;
                        vm_cmd_q <= '{we: 1'b0, addr: px_addr_i,
                            size: PUM_SZ_WORD, wdata: '0, wmask: '0};
                        busy_q <= 1'b1;
                        px_ready_q <= 1'b0;
                        state_q <= PUM_PX_WAIT;
                    end
                end
                PUM_PX_WAIT: begin
                    if (vm_rvalid_i) begin
                        dst_q <= vm_rdata_i[15:0];
                        state_q <= PUM_PX_CALC;
                    end
                end
                PUM_PX_CALC: begin
                    if (calc_go) begin
                        vm_req_q <= pass;
                        vm_cmd_q.we <= 1'b1;
                        vm_cmd_q.wdata <= {16'h0000, new_color};
                        vm_cmd_q.wmask <= plane_mask_q;
                        busy_q <= 1'b0;
                        px_ready_q <= 1'b1;
                        state_q <= PUM_IDLE;
                    end
                end
                PUM_CA_ISSUE: begin
                    vm_req_q <= 1'b1;
                    vm_cmd_q <= '{we: 1'b0, addr: base_q + PUM_AW'(fill_k_q),
                        size: size_q, wdata: '0, wmask: '0};
                    state_q <= PUM_CA_WAIT;
                end
                PUM_CA_WAIT: begin
                    if (vm_rvalid_i) begin
                        fill_k_q <= fill_k_q + 3'h1;
                        state_q <= (fill_k_q == cnt_q) ? PUM_CA_ANSWER
                                                       : PUM_CA_ISSUE;
                    end
                end
                default: begin
                    mdata_q <= line_q[req_idx_q];
                    mvalid_q <= 1'b1;
                    busy_q <= 1'b0;
                    px_ready_q <= 1'b1;
                    state_q <= PUM_IDLE;
                end
            endcase
        end
    end

    // Cache line storage
    always_ff @(posedge clk_sys_i) begin
        if (state_q == PUM_CA_WAIT && vm_rvalid_i) begin
            line_q[fill_k_q] <= vm_rdata_i;
        end
    end

    // Cache validity: any write drops the run, never patches it
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cache_valid_q <= 1'b0;
            stale_q <= 1'b0;
        end else begin
            if (mem_write) begin
                cache_valid_q <= 1'b0;
            end else if (state_q == PUM_CA_ANSWER) begin
                cache_valid_q <= cache_en_i && !stale_q;
            end
            if (state_q == PUM_IDLE) begin
                stale_q <= 1'b0;
            end else if (mem_write) begin
                stale_q <= 1'b1;
            end
        end
    end

    // Outputs straight from flip-flops
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            px_fifo_full_o <= 1'b0;
        end else begin
            px_fifo_full_o <= !fifo_in_ready;
        end
    end
    assign io_rdata_o = io_rdata_q;
    assign cpu_mbusy_o = busy_q;
    assign cpu_mvalid_o = mvalid_q;
    assign cpu_mdata_o = mdata_q;
    assign px_ready_o = px_ready_q;
    assign vm_req_o = vm_req_q;
    assign vm_cmd_o = vm_cmd_q;

    // Checks
    property p_hit_fast;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == PUM_IDLE && cpu_mrd_i && hit) |=> mvalid_q && !vm_req_q;
    endproperty
    a_hit_fast: assert property (p_hit_fast)
        else $error("Cache hit not answered at once");

    property p_fill_unit;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (vm_req_q && !vm_cmd_q.we && state_q == PUM_CA_WAIT) |->
            vm_cmd_q.size == size_q && fill_k_q <= cnt_q;
    endproperty
    a_fill_unit: assert property (p_fill_unit)
        else $error("Prefetch read outside the run or unit");

    property p_inval;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        cpu_mwr_i |=> !cache_valid_q;
    endproperty
    a_inval: assert property (p_inval)
        else $error("Cache still valid after a memory write");

    property p_cmp_off;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (calc_go && !misc_q[PUM_MISC_CMP_EN]) |=>
            vm_req_q && vm_cmd_q.we && vm_cmd_q.wdata[15:0] == $past(new_color);
    endproperty
    a_cmp_off: assert property (p_cmp_off)
        else $error("Colour not passed with compare off");

    property p_wmask;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (vm_req_q && vm_cmd_q.we) |-> vm_cmd_q.wmask == $past(plane_mask_q);
    endproperty
    a_wmask: assert property (p_wmask)
        else $error("Pixel write with wrong plane mask");

    property p_cmp_block;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (calc_go && misc_q[PUM_MISC_CMP_EN] &&
         ((new_color == cmp_color_q) == misc_q[PUM_MISC_SENSE])) |=>
            !vm_req_q && px_ready_q;
    endproperty
    a_cmp_block: assert property (p_cmp_block)
        else $error("Pixel written though compare failed");

    property p_mask_one;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (msrc == PUM_MSK_ONE || msrc == 2'h1) |-> mix_sel == fore_mix_q;
    endproperty
    a_mask_one: assert property (p_mask_one)
        else $error("Forced mask did not select foreground mix");

    property p_bitmap_mask;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (msrc == PUM_MSK_BITMAP && ((dst_q & plane_mask_q) != plane_mask_q))
            |-> mix_sel == back_mix_q;
    endproperty
    a_bitmap_mask: assert property (p_bitmap_mask)
        else $error("Bitmap mask zero did not select background mix");

    property p_cpu_wait;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (state_q == PUM_PX_CALC && need_cpu && !armed_q) |=>
            state_q == PUM_PX_CALC;
    endproperty
    a_cpu_wait: assert property (p_cpu_wait)
        else $error("CPU mask taken before a draw command");
endmodule

// *** rtl/pum_pkg.sv ***
/*
 * Shared constants and types for the pixel update and mix datapath:
 * I/O port addresses, field positions, selector codes, sequencer states
 * and the video memory request carrier.
 * Assumes a 16-bit I/O port space and a 22-bit video memory unit address.
 */
package pum_pkg;

    // I/O port addresses, all 16 address bits decoded
    localparam logic [15:0] PUM_ADR_DRAW_CMD = 16'h9ae8;
    localparam logic [15:0] PUM_ADR_BACK_COLOR = 16'ha2e8;
    localparam logic [15:0] PUM_ADR_FORE_COLOR = 16'ha6e8;
    localparam logic [15:0] PUM_ADR_PLANE_MASK = 16'haae8;
    localparam logic [15:0] PUM_ADR_CMP_COLOR = 16'hb2e8;
    localparam logic [15:0] PUM_ADR_BACK_MIX = 16'hb6e8;
    localparam logic [15:0] PUM_ADR_FORE_MIX = 16'hbae8;
    localparam logic [15:0] PUM_ADR_MULTI = 16'hbee8;
    localparam logic [15:0] PUM_ADR_PIX_LOW = 16'he2e8;
    localparam logic [15:0] PUM_ADR_PIX_HIGH = 16'he2ea;

    // Index in the top nibble of a shared multifunction write
    localparam int PUM_IDX_HI = 15;
    localparam int PUM_IDX_LO = 12;
    localparam logic [3:0] PUM_IDX_MASK_SRC = 4'ha;
    localparam logic [3:0] PUM_IDX_MISC = 4'he;

    // Field positions
    localparam int PUM_MISC_CMP_EN = 8;
    localparam int PUM_MISC_SENSE = 7;
    localparam int PUM_MSRC_HI = 7;
    localparam int PUM_MSRC_LO = 6;
    localparam int PUM_MIX_SRC_HI = 6;
    localparam int PUM_MIX_SRC_LO = 5;
    localparam int PUM_MIX_OP_HI = 3;
    localparam int PUM_MIX_OP_LO = 0;

    // Register reset value
    localparam logic [15:0] PUM_REG_RST = 16'h0000;

    // Colour source and mask source codes
    localparam logic [1:0] PUM_SRC_BACK = 2'h0;
    localparam logic [1:0] PUM_SRC_FORE = 2'h1;
    localparam logic [1:0] PUM_SRC_CPU = 2'h2;
    localparam logic [1:0] PUM_SRC_BITMAP = 2'h3;
    localparam logic [1:0] PUM_MSK_ONE = 2'h0;
    localparam logic [1:0] PUM_MSK_CPU = 2'h2;
    localparam logic [1:0] PUM_MSK_BITMAP = 2'h3;

    // Access unit sizes: linear access counts as doubleword
    localparam logic [1:0] PUM_SZ_BYTE = 2'h0;
    localparam logic [1:0] PUM_SZ_WORD = 2'h1;
    localparam logic [1:0] PUM_SZ_DWORD = 2'h2;

    // Geometry
    localparam int PUM_AW = 22;
    localparam int PUM_FIFO_DEPTH = 16;
    localparam int PUM_FIFO_WIDTH = 16;
    localparam int PUM_LINE_DEPTH = 8;

    typedef enum {
        PUM_IDLE,
        PUM_PX_WAIT,
        PUM_PX_CALC,
        PUM_CA_ISSUE,
        PUM_CA_WAIT,
        PUM_CA_ANSWER
    } pum_state_e;

    typedef struct packed {
        logic we;
        logic [PUM_AW-1:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
        logic [15:0] wmask;
    } pum_vm_req_s;

endpackage

// *** tb/pixel_update_mix_datapath_bench.sv ***
/*
 * Bench for pum_datapath: registers, mixes, compare gate, plane mask,
 * bitmap mask source and read-ahead cache. Assumes pum_vmem_model.
 */
`timescale 1ns/1ps
module pixel_update_mix_datapath_bench;
    import pum_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic cache_en_i = 1'b0, cpu_mrd_i = 1'b0, cpu_mwr_i = 1'b0;
    logic px_valid_i = 1'b0, vm_req_o, vm_rvalid_i, px_ready_o, cpu_mvalid_o;
    logic cpu_mbusy_o, px_fifo_full_o;
    logic [15:0] io_addr_i = 16'h0, io_wdata_i = 16'h0, io_rdata_o;
    logic [2:0] prefetch_cnt_i = 3'h0;
    logic [1:0] access_size_i = 2'h0;
    logic [PUM_AW-1:0] cpu_maddr_i = '0, px_addr_i = '0;
    logic [31:0] cpu_mdata_o, vm_rdata_i;
    pum_vm_req_s vm_cmd_o;
    int error_cnt = 0, n_compared = 0, rd_cnt;
    always #4 clk_sys_i = ~clk_sys_i;
    pum_datapath dut (.clk_sys_i, .rstn_i, .io_wr_i, .io_rd_i, .io_addr_i,
        .io_wdata_i, .io_rdata_o, .px_fifo_full_o, .cache_en_i,
        .prefetch_cnt_i, .access_size_i, .cpu_mrd_i, .cpu_mwr_i, .cpu_maddr_i,
        .cpu_mbusy_o, .cpu_mvalid_o, .cpu_mdata_o, .px_valid_i, .px_addr_i,
        .px_ready_o, .vm_req_o, .vm_cmd_o, .vm_rdata_i, .vm_rvalid_i);
    pum_vmem_model vmem (.clk_sys_i, .rstn_i, .vm_req_i(vm_req_o),
        .vm_cmd_i(vm_cmd_o), .vm_rdata_o(vm_rdata_i),
        .vm_rvalid_o(vm_rvalid_i), .rd_cnt);
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Polls just after each edge; 0 waits for px_ready_o, 1 for cpu_mvalid_o
    task automatic wait_hi(input int which);
        repeat (200) begin
            if ((which ? cpu_mvalid_o : px_ready_o) === 1'b1) return;
            @(posedge clk_sys_i);
            #1;
        end
        check("timeout", 32'h1, 32'h0);
        give_verdict();
    endtask
    task automatic io_acc(input logic wr, input logic [15:0] a, d);
        io_wr_i = wr;
        io_rd_i = !wr;
        io_addr_i = a;
        io_wdata_i = d;
        @(posedge clk_sys_i);
        #1;
        io_wr_i = 1'b0;
        io_rd_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic io_chk(input logic [15:0] a, exp);
        io_acc(1'b0, a, 16'h0);
        check("io read", {16'h0, io_rdata_o}, {16'h0, exp});
    endtask
    // One pixel through the engine, then the stored word is judged
    task automatic pixel(input logic [21:0] a, input logic [15:0] exp);
        px_valid_i = 1'b1;
        px_addr_i = a;
        wait_hi(0);
        @(posedge clk_sys_i);
        #1;
        px_valid_i = 1'b0;
        wait_hi(0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        check("bitmap word", {16'h0, vmem.mem[a[5:0]][15:0]}, {16'h0, exp});
    endtask
    task automatic cpu_rd(input logic [21:0] a, input int reads);
        int r0;
        r0 = rd_cnt;
        cpu_mrd_i = 1'b1;
        cpu_maddr_i = a;
        @(posedge clk_sys_i);
        #1;
        cpu_mrd_i = 1'b0;
        check("busy", {31'h0, cpu_mbusy_o}, 32'(reads != 0));
        wait_hi(1);
        check("cpu data", cpu_mdata_o, 32'h5a5a5a00 | 32'(a));
        check("vm reads", 32'(rd_cnt - r0), 32'(reads));
    endtask
    task automatic sc_regs();
        io_acc(1'b1, PUM_ADR_BACK_COLOR, 16'h0011);
        io_chk(PUM_ADR_BACK_COLOR, 16'h0011);
        io_chk(16'h1234, 16'h0000);
    endtask
    task automatic sc_mix();
        io_acc(1'b1, PUM_ADR_FORE_COLOR, 16'h00c3);
        io_acc(1'b1, PUM_ADR_PLANE_MASK, 16'h00ff);
        io_acc(1'b1, PUM_ADR_FORE_MIX, 16'h0027);
        pixel(22'h2, 16'h5ac3);
        io_acc(1'b1, PUM_ADR_FORE_MIX, 16'h0025);
        pixel(22'h2, 16'h5a00);
        io_acc(1'b1, PUM_ADR_DRAW_CMD, 16'h0000);
        io_acc(1'b1, PUM_ADR_PIX_LOW, 16'h0077);
        io_acc(1'b1, PUM_ADR_FORE_MIX, 16'h0047);
        pixel(22'h5, 16'h5a77);
    endtask
    task automatic sc_compare();
        io_acc(1'b1, PUM_ADR_FORE_MIX, 16'h0027);
        io_acc(1'b1, PUM_ADR_MULTI, 16'he100);
        pixel(22'h3, 16'h5a03);
        io_acc(1'b1, PUM_ADR_MULTI, 16'he180);
        pixel(22'h3, 16'h5ac3);
        io_acc(1'b1, PUM_ADR_CMP_COLOR, 16'h00c3);
        io_acc(1'b1, PUM_ADR_MULTI, 16'he100);
        pixel(22'h6, 16'h5ac3);
        io_acc(1'b1, PUM_ADR_MULTI, 16'he000);
    endtask
    // CPU mask bits pick the mix per pixel, colour from registers
    task automatic sc_cpu_mask();
        io_acc(1'b1, PUM_ADR_MULTI, 16'ha080);
        io_acc(1'b1, PUM_ADR_PIX_LOW, 16'h0001);
        io_acc(1'b1, PUM_ADR_PIX_LOW, 16'h0000);
        pixel(22'ha, 16'h5ac3);
        pixel(22'hb, 16'h5a11);
        repeat (16) io_acc(1'b1, PUM_ADR_PIX_HIGH, 16'h0000);
        check("fifo full", {31'h0, px_fifo_full_o}, 32'h1);
    endtask
    // Bitmap as mask source while colour comes from a register
    task automatic sc_bitmap_mask();
        io_acc(1'b1, PUM_ADR_BACK_MIX, 16'h0007);
        io_acc(1'b1, PUM_ADR_MULTI, 16'ha0c0);
        pixel(22'h4, 16'h5a11);
    endtask
    task automatic sc_cache();
        cache_en_i = 1'b1;
        prefetch_cnt_i = 3'h1;
        access_size_i = PUM_SZ_DWORD;
        cpu_rd(22'h8, 2);
        cpu_rd(22'h9, 0);
        cpu_mwr_i = 1'b1;
        cpu_maddr_i = 22'h9;
        @(posedge clk_sys_i);
        #1;
        cpu_mwr_i = 1'b0;
        cpu_rd(22'h9, 2);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        sc_regs();
        sc_mix();
        sc_compare();
        sc_bitmap_mask();
        sc_cpu_mask();
        sc_cache();
        give_verdict();
    end
endmodule

// *** tb/pum_vmem_model.sv ***
/*
 * Video memory partner: 64 words, reads answered after a fixed latency.
 * Assumes one outstanding read at a time, as the datapath promises.
 */
`timescale 1ns/1ps
module pum_vmem_model #(
    parameter int LAT = 3
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic vm_req_i,
    input wire pum_pkg::pum_vm_req_s vm_cmd_i,
    output logic [31:0] vm_rdata_o,
    output logic vm_rvalid_o,
    output int rd_cnt
);
    import pum_pkg::*;
    logic [31:0] mem [64];
    logic [5:0] ra_q;
    int wait_q;
    // Known contents so expectations follow from the address
    initial for (int i = 0; i < 64; i++) mem[i] = 32'h5a5a5a00 | i;
    // Reads return late; a released data bus shows churn, not old data
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_q <= 0;
            rd_cnt <= 0;
            vm_rvalid_o <= 1'b0;
            vm_rdata_o <= 32'h0;
        end else begin
            vm_rvalid_o <= (wait_q == 1);
            vm_rdata_o <= (wait_q == 1) ? mem[ra_q] : ~vm_rdata_o;
            if (wait_q > 0) wait_q <= wait_q - 1;
            if (vm_req_i && !vm_cmd_i.we) begin
                wait_q <= LAT;
                ra_q <= vm_cmd_i.addr[5:0];
                rd_cnt <= rd_cnt + 1;
            end
            if (vm_req_i && vm_cmd_i.we)
                mem[vm_cmd_i.addr[5:0]][15:0] <=
                    (mem[vm_cmd_i.addr[5:0]][15:0] & ~vm_cmd_i.wmask) |
                    (vm_cmd_i.wdata[15:0] & vm_cmd_i.wmask);
        end
    end
endmodule
